// ### core/bmmc_consts.svh
// Purpose: constants of the brake and manual motor control block
// Assumes: 20 MHz ref_clk, 32-bit AXI4-Lite register access
// Notes: offsets are byte addresses; BMMC_A_TAB_HI is the upper nibble of the table offsets
// Summary of operation
// [RULE1] after power on wait power_to_release_delay ms before releasing brake
// [RULE2] after release wait release_to_ready_delay ms; motion held until then
// [RULE3] after motor stop wait stop_to_engage_delay ms before engaging brake
// [RULE4] after engaging wait engage_to_poweroff_delay ms before removing power
// [RULE5] brake sequencing runs only while brake enable flag is set
// [RULE6] with brake_cuts_power set, engaging brake also switches motor power off
// [RULE7] current in mA is slope times ADC code plus offset
// [RULE8] winding A, winding B and total current each have own slope/offset
// [RULE9] manual mode field: 0 off, 1 joystick, 2 left/right buttons
// [RULE10] left_button_open_pressed set: open left contact means pressed
// [RULE11] right_button_open_pressed set: open right contact means pressed
// [RULE12] full joystick deflection drives toward speed table entry at index
// [RULE13] speed index starts at zero, is kept, and buttons change it
// [RULE14] button press starts motion in its direction at first table entry
// [RULE15] held button steps to entry i+1 when timeout of entry i expires
// [RULE16] speed changes between entries follow the acceleration ramp
// [RULE17] first table speed is not applied before click_window expires
// [RULE18] per-entry timeouts apply in button mode only, not joystick mode
// [RULE19] brake disabled: motion ready as soon as power is applied
// [RULE20] table entry is full steps plus microstep fraction per step division
`ifndef BMMC_CONSTS_SVH
`define BMMC_CONSTS_SVH
`define BMMC_ADDR_W 8
`define BMMC_A_DELAY_RISE 8'h00
`define BMMC_A_DELAY_FALL 8'h04
`define BMMC_A_BRAKE_FLAGS 8'h08
`define BMMC_A_MANUAL 8'h0c
`define BMMC_A_DRIVE 8'h10
`define BMMC_A_CAL_A 8'h14
`define BMMC_A_CAL_B 8'h18
`define BMMC_A_CAL_T 8'h1c
`define BMMC_A_CUR_A 8'h20
`define BMMC_A_CUR_B 8'h24
`define BMMC_A_CUR_T 8'h28
`define BMMC_A_STATUS 8'h2c
`define BMMC_A_TAB_HI 4'h3
`define BMMC_A_TMO_LO 8'h40
`define BMMC_A_TMO_HI 8'h44
`define BMMC_F_LO 15:0
`define BMMC_F_HI 31:16
`define BMMC_BRK_EN 0
`define BMMC_BRK_CUT 1
`define BMMC_MODE 1:0
`define BMMC_LEFT_OPEN 2
`define BMMC_RIGHT_OPEN 3
`define BMMC_PWR_REQ 0
`define BMMC_USTEP 7:4
`define BMMC_TAB_FULL 16:0
`define BMMC_TAB_FRAC 31:24
`define BMMC_MODE_OFF 2'h0
`define BMMC_MODE_JOY 2'h1
`define BMMC_MODE_BTN 2'h2
`define BMMC_USTEP_MAX 4'h8
`define BMMC_IDX_MAX 2'h3
`define BMMC_TAB_N 4
`define BMMC_CAL_FRAC 8
`define BMMC_JOY_FULL 8'h7f
`define BMMC_JOY_SCALE 8'h80
`define BMMC_JOY_SHIFT 7
`define BMMC_SPD_W 26
`define BMMC_RESP_OKAY 2'b00
`define BMMC_RESP_SLVERR 2'b10
`define BMMC_CLK_NS 50
`define BMMC_MS_NS 1000000
`define BMMC_MS_CYCLES (`BMMC_MS_NS / `BMMC_CLK_NS)
`endif

// ### core/bmmc_pkg.sv
// Purpose: types of the brake and manual motor control block
// Assumes: constants header alongside
// Notes: brake states are gray along the power-up and park path
`include "bmmc_consts.svh"
`default_nettype none
package bmmc_pkg;
  typedef enum logic [2:0] {
    BK_OFF = 3'h0, BK_PWR_WAIT = 3'h1, BK_REL_WAIT = 3'h3, BK_READY = 3'h2,
    BK_STOP_WAIT = 3'h6, BK_ENG_WAIT = 3'h7, BK_PARKED = 3'h5
  } bmmc_brake_state_type;
  typedef enum logic [1:0] {
    BT_IDLE = 2'h0, BT_CLICK = 2'h1, BT_RUN = 2'h3
  } bmmc_btn_state_type;
  typedef struct packed {
    logic awvalid;
    logic [`BMMC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`BMMC_ADDR_W-1:0] araddr;
    logic rready;
  } bmmc_axi_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bmmc_axi_resp_type;
  typedef struct packed {
    logic motor_power;
    logic brake_release;
    logic motion_ready;
    logic step_dir;
    logic [`BMMC_SPD_W-1:0] speed;
  } bmmc_drive_type;
endpackage : bmmc_pkg
`default_nettype wire

// ### core/bmmc_top.sv
// Purpose: brake sequencing, current scaling and manual speed control
// Assumes: adc, joystick and motion engine inputs share ref_clk; buttons are pins
// Notes: speed is in microsteps per second, ramped once per millisecond
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`include "bmmc_consts.svh"
`default_nettype none
module bmmc_top
  import bmmc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `BMMC_MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register bus
  input wire bmmc_axi_req_type axi_req,
  output var bmmc_axi_resp_type axi_resp,
  // motion engine
  input wire logic motor_stopped,
  input wire logic move_req,
  output var bmmc_drive_type drive,
  // current adc
  input wire logic adc_valid,
  input wire logic [11:0] adc_a,
  input wire logic [11:0] adc_b,
  input wire logic [11:0] adc_t,
  // manual controls
  input wire logic [7:0] joy_value,
  input wire logic btn_left_pin,
  input wire logic btn_right_pin
);

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] to_ma(input logic [31:0] cal, input logic [11:0] code);
    logic signed [31:0] prod;
    prod = 32'(signed'(cal[`BMMC_F_LO]) * signed'({1'b0, code}));
    return 32'((prod >>> `BMMC_CAL_FRAC) + 32'(signed'(cal[`BMMC_F_HI])));
  endfunction : to_ma

  function automatic logic [`BMMC_SPD_W-1:0] tab_speed(input logic [31:0] ent,
                                                      input logic [3:0] us);
    logic [3:0] m;
    logic [7:0] mask;
    m = (us > `BMMC_USTEP_MAX) ? `BMMC_USTEP_MAX : us;
    mask = 8'((9'h1 << m) - 9'h1);
    return (`BMMC_SPD_W'(ent[`BMMC_TAB_FULL]) << m) + `BMMC_SPD_W'(ent[`BMMC_TAB_FRAC] & mask);
  endfunction : tab_speed

  // configuration and status storage
  logic [31:0] rise_reg, fall_reg, bflag_reg, manual_reg, drv_reg;
  logic [31:0] cal_a_reg, cal_b_reg, cal_t_reg;
  logic [31:0] cur_a_reg, cur_b_reg, cur_t_reg;
  logic [31:0] tab_reg [`BMMC_TAB_N];
  logic [31:0] tmo_lo_reg, tmo_hi_reg;
  bmmc_brake_state_type state_reg, state_next;
  bmmc_btn_state_type bt_reg;
  logic power_reg, release_reg, ready_reg, dir_reg;
  logic [`BMMC_SPD_W-1:0] applied_reg;
  logic [1:0] idx_reg, bidx_reg;
  logic bt_dir_reg;

  // millisecond tick
  logic [31:0] div_reg;
  logic tick_reg;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else if (div_reg >= MS_CYCLES - 1) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  // axi4-lite slave
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [`BMMC_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic wr_fire;
  logic [`BMMC_ADDR_W-1:0] wa;
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wa = aw_addr_reg;

  function automatic logic writable(input logic [`BMMC_ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a <= `BMMC_A_CAL_T || a[7:4] == `BMMC_A_TAB_HI ||
         a == `BMMC_A_TMO_LO || a == `BMMC_A_TMO_HI);
    return ok;
  endfunction : writable

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `BMMC_RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else begin
      if (axi_req.awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= axi_req.awaddr;
      end
      if (axi_req.wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        w_hold_reg <= 1'b1;
        w_data_reg <= axi_req.wdata;
        w_strb_reg <= axi_req.wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= writable(wa) ? `BMMC_RESP_OKAY : `BMMC_RESP_SLVERR;
      end
      if (bvalid_reg && axi_req.bready) begin
        bvalid_reg <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  function automatic logic [33:0] rd_word(input logic [`BMMC_ADDR_W-1:0] a);
    logic [33:0] r;
    r = {`BMMC_RESP_OKAY, 32'h0};
    case (a)
      `BMMC_A_DELAY_RISE: r[31:0] = rise_reg;
      `BMMC_A_DELAY_FALL: r[31:0] = fall_reg;
      `BMMC_A_BRAKE_FLAGS: r[31:0] = bflag_reg;
      `BMMC_A_MANUAL: r[31:0] = manual_reg;
      `BMMC_A_DRIVE: r[31:0] = drv_reg;
      `BMMC_A_CAL_A: r[31:0] = cal_a_reg;
      `BMMC_A_CAL_B: r[31:0] = cal_b_reg;
      `BMMC_A_CAL_T: r[31:0] = cal_t_reg;
      `BMMC_A_CUR_A: r[31:0] = cur_a_reg;
      `BMMC_A_CUR_B: r[31:0] = cur_b_reg;
      `BMMC_A_CUR_T: r[31:0] = cur_t_reg;
      `BMMC_A_STATUS: r[31:0] = {18'h0, idx_reg, bidx_reg, bt_dir_reg, bt_reg, dir_reg,
                                 state_reg, ready_reg, release_reg, power_reg};
      `BMMC_A_TMO_LO: r[31:0] = tmo_lo_reg;
      `BMMC_A_TMO_HI: r[31:0] = tmo_hi_reg;
      default: begin
        if (a[7:4] == `BMMC_A_TAB_HI && a[1:0] == 2'h0) begin
          r[31:0] = tab_reg[a[3:2]];
        end else begin
          r[33:32] = `BMMC_RESP_SLVERR;
        end
      end
    endcase
    return r;
  endfunction : rd_word

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `BMMC_RESP_OKAY;
    end else if (axi_req.arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      {rresp_reg, rdata_reg} <= rd_word(axi_req.araddr);
    end else if (rvalid_reg && axi_req.rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign axi_resp = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg,
                      bresp: bresp_reg, arready: arready_reg, rvalid: rvalid_reg,
                      rdata: rdata_reg, rresp: rresp_reg};

  // register writes
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rise_reg <= 32'h0;
      fall_reg <= 32'h0;
      bflag_reg <= 32'h0;
      manual_reg <= 32'h0;
      drv_reg <= 32'h0;
      cal_a_reg <= 32'h0;
      cal_b_reg <= 32'h0;
      cal_t_reg <= 32'h0;
      tmo_lo_reg <= 32'h0;
      tmo_hi_reg <= 32'h0;
      for (int i = 0; i < `BMMC_TAB_N; i++) begin
        tab_reg[i] <= 32'h0;
      end
    end else if (wr_fire) begin
      case (wa)
        `BMMC_A_DELAY_RISE: rise_reg <= merge(rise_reg, w_data_reg, w_strb_reg);
        `BMMC_A_DELAY_FALL: fall_reg <= merge(fall_reg, w_data_reg, w_strb_reg);
        `BMMC_A_BRAKE_FLAGS: bflag_reg <= {30'h0, 2'(w_strb_reg[0] ? w_data_reg : bflag_reg)};
        `BMMC_A_MANUAL: manual_reg <= merge(manual_reg, w_data_reg, w_strb_reg) & 32'hffff000f;
        `BMMC_A_DRIVE: drv_reg <= merge(drv_reg, w_data_reg, w_strb_reg) & 32'hffff00f1;
        `BMMC_A_CAL_A: cal_a_reg <= merge(cal_a_reg, w_data_reg, w_strb_reg); // RULE8
        `BMMC_A_CAL_B: cal_b_reg <= merge(cal_b_reg, w_data_reg, w_strb_reg); // RULE8
        `BMMC_A_CAL_T: cal_t_reg <= merge(cal_t_reg, w_data_reg, w_strb_reg); // RULE8
        `BMMC_A_TMO_LO: tmo_lo_reg <= merge(tmo_lo_reg, w_data_reg, w_strb_reg);
        `BMMC_A_TMO_HI: tmo_hi_reg <= merge(tmo_hi_reg, w_data_reg, w_strb_reg);
        default: begin
          if (wa[7:4] == `BMMC_A_TAB_HI && wa[1:0] == 2'h0) begin
            tab_reg[wa[3:2]] <= merge(tab_reg[wa[3:2]], w_data_reg, w_strb_reg) & 32'hff01ffff;
          end
        end
      endcase
    end
  end

  // current scaling
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur_a_reg <= 32'h0;
      cur_b_reg <= 32'h0;
      cur_t_reg <= 32'h0;
    end else if (adc_valid) begin
      cur_a_reg <= to_ma(cal_a_reg, adc_a); // RULE7
      cur_b_reg <= to_ma(cal_b_reg, adc_b); // RULE7
      cur_t_reg <= to_ma(cal_t_reg, adc_t); // RULE7
    end
  end

  // button synchronisers and press decode
  logic l_s1_reg, l_s2_reg, r_s1_reg, r_s2_reg, l_prev_reg, r_prev_reg;
  logic l_prs, r_prs, l_edge, r_edge;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {l_s1_reg, l_s2_reg, r_s1_reg, r_s2_reg} <= 4'h0;
      {l_prev_reg, r_prev_reg} <= 2'h0;
    end else begin
      {l_s1_reg, l_s2_reg} <= {btn_left_pin, l_s1_reg};
      {r_s1_reg, r_s2_reg} <= {btn_right_pin, r_s1_reg};
      {l_prev_reg, r_prev_reg} <= {l_prs, r_prs};
    end
  end
  // pin high means contact closed
  assign l_prs = l_s2_reg ^ manual_reg[`BMMC_LEFT_OPEN]; // RULE10
  assign r_prs = r_s2_reg ^ manual_reg[`BMMC_RIGHT_OPEN]; // RULE11
  assign l_edge = l_prs & ~l_prev_reg;
  assign r_edge = r_prs & ~r_prev_reg;

  logic [1:0] mode;
  logic [3:0] ustep;
  assign mode = manual_reg[`BMMC_MODE];
  assign ustep = drv_reg[`BMMC_USTEP];

  // joystick speed index, kept across mode changes
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      idx_reg <= 2'h0; // RULE13
    end else if (mode == `BMMC_MODE_JOY) begin
      if (r_edge && idx_reg != `BMMC_IDX_MAX) begin
        idx_reg <= idx_reg + 2'h1; // RULE13
      end else if (l_edge && idx_reg != 2'h0) begin
        idx_reg <= idx_reg - 2'h1; // RULE13
      end
    end
  end

  // button drive sequencer
  logic [15:0] bcnt_reg, cur_tmo;
  logic held;
  assign held = bt_dir_reg ? r_prs : l_prs;
  always_comb begin
    case (bidx_reg)
      2'h0: cur_tmo = tmo_lo_reg[`BMMC_F_LO];
      2'h1: cur_tmo = tmo_lo_reg[`BMMC_F_HI];
      2'h2: cur_tmo = tmo_hi_reg[`BMMC_F_LO];
      default: cur_tmo = tmo_hi_reg[`BMMC_F_HI];
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bt_reg <= BT_IDLE;
      bidx_reg <= 2'h0;
      bt_dir_reg <= 1'b0;
      bcnt_reg <= 16'h0;
    end else if (mode != `BMMC_MODE_BTN) begin
      bt_reg <= BT_IDLE; // RULE18
      bidx_reg <= 2'h0;
      bcnt_reg <= 16'h0;
    end else begin
      if (tick_reg && bcnt_reg != 16'hffff) begin
        bcnt_reg <= bcnt_reg + 16'h1;
      end
      case (bt_reg)
        BT_IDLE: begin
          bcnt_reg <= 16'h0;
          bidx_reg <= 2'h0;
          if (l_prs ^ r_prs) begin
            bt_reg <= BT_CLICK;
            bt_dir_reg <= r_prs; // RULE14
          end
        end
        BT_CLICK: begin
          if (!held) begin
            bt_reg <= BT_IDLE;
          end else if (bcnt_reg > manual_reg[`BMMC_F_HI]) begin
            bt_reg <= BT_RUN; // RULE17
            bcnt_reg <= 16'h0;
          end
        end
        BT_RUN: begin
          if (!held) begin
            bt_reg <= BT_IDLE;
          end else if (bidx_reg != `BMMC_IDX_MAX && bcnt_reg > cur_tmo) begin
            bidx_reg <= bidx_reg + 2'h1; // RULE15
            bcnt_reg <= 16'h0;
          end
        end
        default: bt_reg <= BT_IDLE;
      endcase
    end
  end

  // manual target speed
  logic [7:0] jmag, jscale;
  logic [`BMMC_SPD_W-1:0] target;
  logic tdir;
  assign jmag = joy_value[7] ? 8'(-joy_value) : joy_value;
  assign jscale = (jmag >= `BMMC_JOY_FULL) ? `BMMC_JOY_SCALE : jmag;
  always_comb begin
    target = '0;
    tdir = dir_reg;
    case (mode)
      `BMMC_MODE_JOY: begin
        target = `BMMC_SPD_W'((tab_speed(tab_reg[idx_reg], ustep) * jscale) >> `BMMC_JOY_SHIFT); // RULE12 RULE20
        tdir = ~joy_value[7];
      end
      `BMMC_MODE_BTN: begin
        if (bt_reg == BT_RUN) begin
          target = tab_speed(tab_reg[bidx_reg], ustep); // RULE14 RULE15 RULE20
        end
        tdir = bt_dir_reg;
      end
      default: target = '0; // RULE9
    endcase
  end

  // brake sequencer
  logic brake_en, demand, done, manual_active;
  logic [15:0] ms_cnt_reg, delay_sel;
  assign brake_en = bflag_reg[`BMMC_BRK_EN];
  assign manual_active = (target != '0) || (bt_reg != BT_IDLE);
  assign demand = drv_reg[`BMMC_PWR_REQ] & (move_req | manual_active);
  always_comb begin
    case (state_reg)
      BK_PWR_WAIT: delay_sel = rise_reg[`BMMC_F_LO]; // RULE1
      BK_REL_WAIT: delay_sel = rise_reg[`BMMC_F_HI]; // RULE2
      BK_STOP_WAIT: delay_sel = fall_reg[`BMMC_F_LO]; // RULE3
      BK_ENG_WAIT: delay_sel = fall_reg[`BMMC_F_HI]; // RULE4
      default: delay_sel = 16'h0;
    endcase
  end
  // tick phase is free running, so one extra tick guarantees the full delay
  assign done = ms_cnt_reg > delay_sel;

  always_comb begin
    state_next = state_reg;
    if (!brake_en) begin
      state_next = drv_reg[`BMMC_PWR_REQ] ? BK_READY : BK_OFF; // RULE5 RULE19
    end else begin
      case (state_reg)
        BK_OFF: if (demand) state_next = BK_PWR_WAIT;
        BK_PWR_WAIT: begin
          if (!drv_reg[`BMMC_PWR_REQ]) state_next = BK_OFF;
          else if (done) state_next = BK_REL_WAIT; // RULE1
        end
        BK_REL_WAIT: begin
          if (!drv_reg[`BMMC_PWR_REQ]) state_next = BK_STOP_WAIT;
          else if (done) state_next = BK_READY; // RULE2
        end
        BK_READY: if (motor_stopped && !demand) state_next = BK_STOP_WAIT;
        BK_STOP_WAIT: begin
          if (demand) state_next = BK_READY;
          else if (done) state_next = BK_ENG_WAIT; // RULE3
        end
        BK_ENG_WAIT: begin
          if (done) begin
            state_next = (bflag_reg[`BMMC_BRK_CUT] || !drv_reg[`BMMC_PWR_REQ]) ?
                         BK_OFF : BK_PARKED; // RULE4 RULE6
          end
        end
        BK_PARKED: begin
          if (!drv_reg[`BMMC_PWR_REQ]) state_next = BK_OFF;
          else if (demand) state_next = BK_PWR_WAIT;
        end
        default: state_next = BK_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg <= BK_OFF;
      ms_cnt_reg <= 16'h0;
      power_reg <= 1'b0;
      release_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        ms_cnt_reg <= 16'h0;
      end else if (tick_reg && ms_cnt_reg != 16'hffff) begin
        ms_cnt_reg <= ms_cnt_reg + 16'h1;
      end
      power_reg <= (state_next != BK_OFF); // RULE6
      release_reg <= brake_en && (state_next == BK_REL_WAIT || state_next == BK_READY ||
                                  state_next == BK_STOP_WAIT);
      ready_reg <= (state_next == BK_READY); // RULE2 RULE19
    end
  end

  // speed ramp
  logic [`BMMC_SPD_W-1:0] goal, step, diff;
  assign goal = (ready_reg && tdir == dir_reg) ? target : '0; // RULE2
  assign step = `BMMC_SPD_W'(drv_reg[`BMMC_F_HI]);
  assign diff = (goal > applied_reg) ? goal - applied_reg : applied_reg - goal;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      applied_reg <= '0;
      dir_reg <= 1'b0;
    end else begin
      if (applied_reg == '0) begin
        dir_reg <= tdir;
      end
      if (!ready_reg) begin
        applied_reg <= '0;
      end else if (tick_reg && diff != '0) begin
        if (goal > applied_reg) begin
          applied_reg <= applied_reg + ((diff < step) ? diff : step); // RULE16
        end else begin
          applied_reg <= applied_reg - ((diff < step) ? diff : step); // RULE16
        end
      end
    end
  end

  assign drive = '{motor_power: power_reg, brake_release: release_reg,
                   motion_ready: ready_reg, step_dir: dir_reg, speed: applied_reg};

endmodule : bmmc_top
`default_nettype wire

// ### tb/bmmc_props.sv
// Purpose: port checker for bmmc_top
// Assumes: one clock domain, synchronous reset
// Notes: bound to the design below
`default_nettype none
module bmmc_props
  import bmmc_pkg::*;
(
  // watched ports
  input wire logic ref_clk,
  input wire logic rstn,
  input wire bmmc_axi_req_type axi_req,
  input wire bmmc_axi_resp_type axi_resp,
  input wire bmmc_drive_type drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  rel_pwr_a: assert property (
    $rose(drive.brake_release) |-> $past(drive.motor_power)) else $error("early release");
  rdy_rel_a: assert property (
    $rose(drive.motion_ready) && drive.brake_release |-> $past(drive.brake_release))
    else $error("early ready");
  eng_pwr_a: assert property (
    $fell(drive.brake_release) |-> drive.motor_power) else $error("power lost first");
  off_eng_a: assert property (
    $fell(drive.motor_power) |-> !drive.brake_release) else $error("power off, brake free");
  rdy_pwr_a: assert property (
    drive.motion_ready |-> drive.motor_power) else $error("ready without power");
  dir_zero_a: assert property (
    $changed(drive.step_dir) |-> $past(drive.speed) == '0) else $error("dir flip at speed");
  b_rdy_a: assert property (
    axi_resp.bvalid |-> !axi_resp.awready && !axi_resp.wready) else $error("ready early");
  r_lat_a: assert property (
    axi_req.arvalid && axi_resp.arready |=> axi_resp.rvalid) else $error("late rvalid");
endmodule : bmmc_props
bind bmmc_top bmmc_props bmmc_props_i (.ref_clk, .rstn, .axi_req, .axi_resp, .drive);
`default_nettype wire

// ### tb/bmmc_motor.sv
// Purpose: motion engine stand-in
// Assumes: standstill seen one cycle after speed reaches zero
// Notes: none
`default_nettype none
module bmmc_motor
  import bmmc_pkg::*;
(
  // clock and drive
  input wire logic ref_clk,
  input wire bmmc_drive_type drive,
  // engine status
  output var logic motor_stopped
);
  logic stop_reg = 1'b1;
  always_ff @(posedge ref_clk) begin
    stop_reg <= (drive.speed == '0);
  end
  assign motor_stopped = stop_reg;
endmodule : bmmc_motor
`default_nettype wire

// ### tb/bmmc_top_tb.sv
// Purpose: self-checking bench for bmmc_top
// Assumes: MS_CYCLES of 20
// Notes: read results checked from a queue
`default_nettype none
`define TB_CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module bmmc_top_tb
  import bmmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 20;
  logic ref_clk = 0, rstn = 0, adc_valid = 0, move_req = 0;
  logic btn_left_pin = 1, btn_right_pin = 0, motor_stopped;
  logic [11:0] adc_a = 0, adc_b = 0, adc_t = 0;
  logic [7:0] joy_value = 0;
  bmmc_axi_req_type axi_req = '{bready: 1'b1, rready: 1'b1, default: '0};
  bmmc_axi_resp_type axi_resp;
  bmmc_drive_type drive;
  int miscompares = 0, checked = 0, n, e;
  logic [65:0] exp_q[$];
  logic [31:0] mk, ex;
  logic [1:0] rs;
  logic [15:0] t[4], sl[3], of[3];
  logic [11:0] cd[3];
  bmmc_top #(.MS_CYCLES(MS)) bmmc_top_i (.ref_clk, .rstn, .axi_req, .axi_resp,
    .motor_stopped, .move_req, .drive, .adc_valid, .adc_a, .adc_b, .adc_t, .joy_value,
    .btn_left_pin, .btn_right_pin);
  bmmc_motor bmmc_motor_i (.ref_clk, .drive, .motor_stopped);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic lim();
    n++;
    if (n > 3000) begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  endtask : lim
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    n = 0;
    do begin
      @(posedge ref_clk);
      lim();
      if (axi_resp.awready) axi_req.awvalid <= 1'b0;
      if (axi_resp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_resp.bvalid !== 1'b1);
    `TB_CHK(axi_resp.bresp, 2'b00)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({(a < 8'h48) ? 2'b00 : 2'b10, m, v});
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    n = 0;
    do begin
      @(posedge ref_clk);
      lim();
      if (axi_resp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_resp.rvalid !== 1'b1);
  endtask : rd
  // f picks power, release or ready, counted down from the msb
  task automatic wt(input int f, input logic v);
    n = 0;
    while (drive[$bits(drive) - 1 - f] !== v) begin
      @(posedge ref_clk);
      lim();
    end
  endtask : wt
  task automatic win(input int k);
    `TB_CHK(n >= k * MS && n <= (k + 1) * MS + 5, 1'b1)
  endtask : win
  always @(posedge ref_clk) begin
    if (rstn && axi_resp.rvalid === 1'b1) begin
      {rs, mk, ex} = exp_q.pop_front();
      `TB_CHK(axi_resp.rdata & mk, ex)
      `TB_CHK(axi_resp.rresp, rs)
    end
  end
  initial begin
    void'($urandom(86691));
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h00, '1, '0);
    rd(8'h50, '1, '0);
    for (int k = 0; k < 4; k++) t[k] = 16'(1 + $urandom % 3);
    for (int k = 0; k < 3; k++) begin
      sl[k] = 16'($urandom);
      of[k] = 16'($urandom);
      cd[k] = 12'($urandom);
      wr(8'h14 + 8'(4 * k), {of[k], sl[k]});
    end
    adc_a <= cd[0];
    adc_b <= cd[1];
    adc_t <= cd[2];
    adc_valid <= 1'b1;
    @(posedge ref_clk);
    adc_valid <= 1'b0;
    @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      e = (($signed(sl[k]) * $signed({1'b0, cd[k]})) >>> 8) + $signed(of[k]);
      rd(8'h20 + 8'(4 * k), '1, e);
    end
    wr(8'h00, {t[1], t[0]});
    wr(8'h04, {t[3], t[2]});
    wr(8'h08, 32'h3);
    move_req <= 1'b1;
    wr(8'h10, 32'h1);
    wt(0, 1'b1);
    wt(1, 1'b1);
    win(t[0]);
    wt(2, 1'b1);
    win(t[1]);
    move_req <= 1'b0;
    wt(1, 1'b0);
    win(t[2]);
    wt(0, 1'b0);
    win(t[3]);
    wr(8'h08, 32'h0);
    wt(2, 1'b1);
    `TB_CHK(n <= 5, 1'b1)
    `TB_CHK(drive.brake_release, 1'b0)
    wr(8'h40, {16'd10, 16'd3});
    wr(8'h0c, {16'd2, 16'h6});
    btn_right_pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rd(8'h2c, 32'h180, 32'h080);
    repeat (58) @(posedge ref_clk);
    rd(8'h2c, 32'hf80, 32'h380);
    repeat (120) @(posedge ref_clk);
    rd(8'h2c, 32'hf80, 32'h780);
    btn_right_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    btn_left_pin <= 1'b0;
    repeat (70) @(posedge ref_clk);
    rd(8'h2c, 32'hf80, 32'h180);
    btn_left_pin <= 1'b1;
    wr(8'h0c, 32'h5);
    joy_value <= 8'($urandom);
    rd(8'h2c, 32'h3000, 32'h0);
    btn_right_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(8'h2c, 32'h3000, 32'h1000);
    joy_value <= 8'h7f;
    wr(8'h34, 32'h5);
    wr(8'h10, {16'h2, 16'h1});
    repeat (25) @(posedge ref_clk);
    `TB_CHK(drive.speed <= 26'h4, 1'b1)
    repeat (80) @(posedge ref_clk);
    `TB_CHK(drive.speed, 26'h5)
    repeat (2) @(posedge ref_clk);
    stop_test();
  end
endmodule : bmmc_top_tb
`default_nettype wire
